// ---- common/sbwm_map.svh ----
// What this block does
// - x8: selects gate nibbles 3:0 and 7:4
// - x18: selects gate bits 8:0 and 17:9
// - all selects high: nothing written
// - x9: one select gates bits 8:0
// - x36: four selects gate four lanes
// - data and selects taken on both phases
// - after reset deselected, read outputs released
// - second word goes to address plus one
// - read data on output clocks, else input pair
// - burst data at cycles t+1 and t+2
// - writes: select at positive rise, address at negative
`ifndef SBWM_MAP_SVH
`define SBWM_MAP_SVH
`define SBWM_MAX_W      36
`define SBWM_MAX_LN     4
`define SBWM_NIB_W      4
`define SBWM_BYTE_W     9
`define SBWM_ADDR_W     4
`define SBWM_FIFO_DEPTH 8
`define SBWM_STRAP_WAIT 2'h3
`endif

// ---- common/sbwm_pkg.sv ----
`include "sbwm_map.svh"
package sbwm_pkg;
  typedef struct packed {
    logic k;
    logic kn;
    logic c;
    logic cn;
  } sbwm_clks_t;

  typedef struct packed {
    logic                     read_port_select_n;
    logic                     write_port_select_n;
    logic [`SBWM_ADDR_W-1:0]  addr;
    logic [`SBWM_MAX_W-1:0]   data;
    logic [`SBWM_MAX_LN-1:0]  byte_lane_write_select_n;
  } sbwm_pins_t;

  typedef struct packed {
    logic [`SBWM_ADDR_W-1:0]  addr;
    logic [`SBWM_MAX_W-1:0]   w0;
    logic [`SBWM_MAX_LN-1:0]  m0;
    logic [`SBWM_MAX_W-1:0]   w1;
    logic [`SBWM_MAX_LN-1:0]  m1;
  } sbwm_burst_t;

  typedef enum logic [1:0] {WR_IDLE, WR_HALF, WR_PUSH} sbwm_wr_state_t;
  typedef enum logic [2:0] {RD_IDLE, RD_T, RD_T1, RD_Q0, RD_Q1} sbwm_rd_state_t;
endpackage : sbwm_pkg

// ---- design/sbwm_core.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "sbwm_map.svh"
module sbwm_core #(
  parameter int W = 18
) (
  input  wire logic                 i_sys_clk,   // 250 MHz core clock
  input  wire logic                 i_resetn,    // async reset, active low
  input  wire logic                 i_ce,        // clock enable, freezes state
  input  wire sbwm_pkg::sbwm_clks_t i_clks,      // K, K#, C, C# pins
  input  wire sbwm_pkg::sbwm_pins_t i_pins,      // selects, address, data
  output logic                      o_wr_ready,  // burst buffer has room
  output logic [W-1:0]              o_rd_data,   // read data pins
  output logic                      o_rd_oe,     // read data drive enable
  output logic                      o_single_clk // single clock strap seen
);
  import sbwm_pkg::*;

  localparam int LW    = (W == 8) ? `SBWM_NIB_W : `SBWM_BYTE_W;
  localparam int NL    = W / LW;
  localparam int DEPTH = 1 << `SBWM_ADDR_W;
  localparam int BW    = $bits(sbwm_burst_t);

  default clocking cb_sys @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  // pin synchronisers; a third stage on the clocks feeds edge detect
  sbwm_clks_t clk_s1;
  sbwm_clks_t clk_s2;
  sbwm_clks_t clk_prev;
  sbwm_pins_t pin_s1;
  sbwm_pins_t pin_s2;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      // idle-high reset: a clock pin already high at release is no rise
      clk_s1   <= '1;
      clk_s2   <= '1;
      clk_prev <= '1;
      pin_s1   <= '1;
      pin_s2   <= '1;
    end else if (i_ce) begin
      clk_s1   <= i_clks;
      clk_s2   <= clk_s1;
      clk_prev <= clk_s2;
      pin_s1   <= i_pins;
      pin_s2   <= pin_s1;
    end
  end

  wire logic k_rise;
  wire logic kn_rise;
  wire logic c_rise;
  wire logic cn_rise;
  assign k_rise  = clk_s2.k & ~clk_prev.k;
  assign kn_rise = clk_s2.kn & ~clk_prev.kn;
  assign c_rise  = clk_s2.c & ~clk_prev.c;
  assign cn_rise = clk_s2.cn & ~clk_prev.cn;

  // strap is read a few cycles after release, once the synchronisers hold pin levels
  logic       single;
  logic       strap_done;
  logic [1:0] strap_cnt;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      strap_cnt  <= '0;
      strap_done <= 1'b0;
      single     <= 1'b0;
    end else if (i_ce && !strap_done) begin
      if (strap_cnt == `SBWM_STRAP_WAIT) begin
        single     <= clk_s2.c & clk_s2.cn;
        strap_done <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 1'b1;
      end
    end
  end

  assign o_single_clk = single;

  a_strap_fixed: assert property (strap_done |=> $stable(single) && strap_done)
    else $error("single clock strap changed after capture");

  // output clock events fall back to the input pair in single clock mode
  wire logic oc_rise;
  wire logic ocn_rise;
  assign oc_rise  = single ? k_rise : c_rise;
  assign ocn_rise = single ? kn_rise : cn_rise;

  // ---- write capture ----
  sbwm_wr_state_t wr_state;
  sbwm_burst_t    pend;
  wire logic      wr_start;
  wire logic      fifo_in_ready;

  assign wr_start   = wr_state == WR_IDLE && k_rise && !pin_s2.write_port_select_n;
  assign o_wr_ready = fifo_in_ready;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_state <= WR_IDLE;
      pend     <= '0;
    end else if (i_ce) begin
      case (wr_state)
        WR_IDLE: begin
          if (wr_start) begin
            pend.w0  <= pin_s2.data;
            pend.m0  <= pin_s2.byte_lane_write_select_n;
            wr_state <= WR_HALF;
          end
        end
        WR_HALF: begin
          if (kn_rise) begin
            pend.addr <= pin_s2.addr;
            pend.w1   <= pin_s2.data;
            pend.m1   <= pin_s2.byte_lane_write_select_n;
            wr_state  <= WR_PUSH;
          end
        end
        WR_PUSH: begin
          // new bursts are ignored until the buffer takes this one
          if (fifo_in_ready) wr_state <= WR_IDLE;
        end
        default: wr_state <= WR_IDLE;
      endcase
    end
  end

  a_wr_first_portion: assert property (i_ce && wr_start |=>
      wr_state == WR_HALF && pend.w0 == $past(pin_s2.data)
      && pend.m0 == $past(pin_s2.byte_lane_write_select_n))
    else $error("first data portion not captured at positive rise");

  sequence s_half_neg;
    i_ce && wr_state == WR_HALF && kn_rise;
  endsequence
  property p_second_portion;
    s_half_neg |=> wr_state == WR_PUSH && pend.addr == $past(pin_s2.addr)
      && pend.w1 == $past(pin_s2.data) && pend.m1 == $past(pin_s2.byte_lane_write_select_n);
  endproperty
  a_wr_second_portion: assert property (p_second_portion)
    else $error("address or second portion not captured at negative rise");

  // ---- burst buffer and array commit ----
  logic [BW-1:0]           drain_bits;
  sbwm_burst_t             drain;
  wire logic               drain_valid;
  wire logic               commit;
  wire logic               rd_fetch;
  wire logic [`SBWM_ADDR_W-1:0] caddr;
  wire logic [`SBWM_ADDR_W-1:0] caddr_nx;

  sbwm_fifo #(
    .WIDTH (BW),
    .DEPTH (`SBWM_FIFO_DEPTH)
  ) u_fifo (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_ce      (i_ce),
    .i_valid   (wr_state == WR_PUSH),
    .o_ready   (fifo_in_ready),
    .i_data    (pend),
    .o_valid   (drain_valid),
    .i_ready   (!rd_fetch),
    .o_data    (drain_bits)
  );

  // commit yields to a read fetch so the read sees a settled array
  assign drain    = sbwm_burst_t'(drain_bits);
  assign commit   = drain_valid & ~rd_fetch;
  assign caddr    = drain.addr;
  assign caddr_nx = caddr + `SBWM_ADDR_W'(1);

  logic [W-1:0]      mem [DEPTH];
  wire logic [W-1:0] old0;
  wire logic [W-1:0] old1;
  wire logic [W-1:0] merged0;
  wire logic [W-1:0] merged1;
  assign old0 = mem[caddr];
  assign old1 = mem[caddr_nx];

  sbwm_lane_merge #(
    .W  (W),
    .LW (LW),
    .NL (NL)
  ) u_merge0 (
    .i_old   (old0),
    .i_new   (drain.w0[W-1:0]),
    .i_sel_n (drain.m0[NL-1:0]),
    .o_word  (merged0)
  );

  sbwm_lane_merge #(
    .W  (W),
    .LW (LW),
    .NL (NL)
  ) u_merge1 (
    .i_old   (old1),
    .i_new   (drain.w1[W-1:0]),
    .i_sel_n (drain.m1[NL-1:0]),
    .o_word  (merged1)
  );

  // both words land in one cycle so a read never sees half a burst
  always_ff @(posedge i_sys_clk) begin
    if (i_ce && commit) begin
      mem[caddr]    <= merged0;
      mem[caddr_nx] <= merged1;
    end
  end

  a_lane0_written: assert property (i_ce && commit && !drain.m0[0] |=>
      mem[$past(caddr)][LW-1:0] == $past(drain.w0[LW-1:0]))
    else $error("enabled lane 0 not written");
  a_top_lane_kept: assert property (i_ce && commit && drain.m1[NL-1] |=>
      mem[$past(caddr_nx)][W-1:W-LW] == $past(old1[W-1:W-LW]))
    else $error("masked top lane altered");
  a_masked_word_kept: assert property (i_ce && commit && (&drain.m0[NL-1:0]) |=>
      mem[$past(caddr)] == $past(old0))
    else $error("fully masked word altered the array");
  a_burst_next_addr: assert property (i_ce && commit && drain.m1[NL-1:0] == '0 |=>
      mem[$past(caddr_nx)] == $past(drain.w1[W-1:0]))
    else $error("second word not at address plus one");

  // ---- read path, kept to the output timing the write side relies on ----
  sbwm_rd_state_t           rd_state;
  logic [`SBWM_ADDR_W-1:0]  raddr;
  wire logic [`SBWM_ADDR_W-1:0] raddr_nx;
  wire logic                rd_start;
  wire logic [W-1:0]        word_a0;
  wire logic [W-1:0]        word_a1;
  wire logic [W-1:0]        rd_word;

  assign rd_start = rd_state == RD_IDLE && strap_done && k_rise && !pin_s2.read_port_select_n;
  assign raddr_nx = raddr + `SBWM_ADDR_W'(1);
  assign word_a0  = mem[raddr];
  assign word_a1  = mem[raddr_nx];
  assign rd_word  = (rd_state == RD_T1) ? word_a0 : word_a1;
  assign rd_fetch = (rd_state == RD_T1 && ocn_rise) || (rd_state == RD_Q0 && oc_rise);

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rd_state  <= RD_IDLE;
      raddr     <= '0;
      o_rd_data <= '0;
      o_rd_oe   <= 1'b0;
    end else if (i_ce) begin
      case (rd_state)
        RD_IDLE: begin
          if (rd_start) begin
            raddr    <= pin_s2.addr;
            rd_state <= RD_T;
          end
        end
        RD_T: begin
          if (k_rise) rd_state <= RD_T1;
        end
        RD_T1: begin
          if (ocn_rise) begin
            o_rd_data <= rd_word;
            o_rd_oe   <= 1'b1;
            rd_state  <= RD_Q0;
          end
        end
        RD_Q0: begin
          if (oc_rise) begin
            o_rd_data <= rd_word;
            rd_state  <= RD_Q1;
          end
        end
        RD_Q1: begin
          // release after one more output clock rise
          if (ocn_rise) begin
            o_rd_oe  <= 1'b0;
            rd_state <= RD_IDLE;
          end
        end
        default: rd_state <= RD_IDLE;
      endcase
    end
  end

  a_rd_released: assert property (rd_state inside {RD_IDLE, RD_T, RD_T1} |-> !o_rd_oe)
    else $error("read outputs driven with no read in flight");

  sequence s_rd_q0;
    i_ce && rd_state == RD_T1 && ocn_rise;
  endsequence
  sequence s_rd_q1;
    i_ce && rd_state == RD_Q0 && oc_rise;
  endsequence
  a_rd_first_word: assert property (s_rd_q0 |=> o_rd_oe && o_rd_data == $past(word_a0))
    else $error("first read word not from latched address");
  a_rd_second_word: assert property (s_rd_q1 |=> o_rd_oe && o_rd_data == $past(word_a1))
    else $error("second read word not from address plus one");
endmodule : sbwm_core
`default_nettype wire

// ---- design/sbwm_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbwm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_sys_clk, // core clock
  input  wire logic             i_resetn,  // async reset, low
  input  wire logic             i_ce,      // clock enable
  input  wire logic             i_valid,   // fill side valid
  output logic                  o_ready,   // fill side ready
  input  wire logic [WIDTH-1:0] i_data,    // fill data
  output logic                  o_valid,   // drain side valid
  input  wire logic             i_ready,   // drain side ready
  output logic      [WIDTH-1:0] o_data     // drain data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  wire logic        push;
  wire logic        pop;

  assign o_ready = count != (AW+1)'(DEPTH);
  assign o_valid = count != '0;
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem[rd_idx];

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else if (i_ce) begin
      if (push) wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      if (pop) rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_ce && push) mem[wr_idx] <= i_data;
  end

  a_fifo_fill_count: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_ce && push && !pop |=> count == $past(count) + 1'b1)
    else $error("fifo count did not grow on push");
  a_fifo_full_stall: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond its depth");
endmodule : sbwm_fifo
`default_nettype wire

// ---- design/sbwm_lane_merge.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbwm_lane_merge #(
  parameter int W  = 18,
  parameter int LW = 9,
  parameter int NL = 2
) (
  input  wire logic [W-1:0]  i_old,   // word now in the array
  input  wire logic [W-1:0]  i_new,   // word from the bus
  input  wire logic [NL-1:0] i_sel_n, // lane selects, low writes
  output logic      [W-1:0]  o_word   // merged word
);
  genvar g;
  for (g = 0; g < NL; g++) begin : g_lane
    assign o_word[g*LW +: LW] = i_sel_n[g] ? i_old[g*LW +: LW] : i_new[g*LW +: LW];
  end
endmodule : sbwm_lane_merge
`default_nettype wire

// ---- verification/sbwm_ctl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbwm_ctl_model (
  input  wire logic                 i_sys_clk, // core clock
  output var  sbwm_pkg::sbwm_clks_t o_clks,    // pin clocks k, kn, c, cn
  output var  sbwm_pkg::sbwm_pins_t o_pins     // selects, address, data
);
  import sbwm_pkg::*;
  localparam int P  = 6;
  localparam int K  = 3;
  localparam int KN = 2;
  localparam int C  = 1;
  localparam int CN = 0;

  task automatic cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : cyc

  // inputs hold two cycles past the rise, then drift so stale values never pass
  task automatic pulse(input int i);
    o_clks[i] = 1'b0;
    cyc(P);
    o_clks[i] = 1'b1;
    cyc(2);
    o_pins = '{1'b1, 1'b1, ~o_pins.addr, ~o_pins.data, ~o_pins.byte_lane_write_select_n};
    cyc(P - 2);
  endtask : pulse

  task automatic wr(input logic [3:0] a, input logic [35:0] w0, input logic [3:0] m0,
                    input logic [35:0] w1, input logic [3:0] m1);
    o_pins.write_port_select_n      = 1'b0;
    o_pins.data                     = w0;
    o_pins.byte_lane_write_select_n = m0;
    pulse(K);
    o_pins.addr                     = a;
    o_pins.data                     = w1;
    o_pins.byte_lane_write_select_n = m1;
    pulse(KN);
  endtask : wr

  task automatic rd_start(input logic [3:0] a);
    o_pins.read_port_select_n = 1'b0;
    o_pins.addr               = a;
    pulse(K);
    pulse(K);
  endtask : rd_start

  task automatic stop();
    o_clks = 4'hf;
  endtask : stop

  initial begin
    o_clks = 4'hd;
    o_pins = '1;
  end
endmodule : sbwm_ctl_model
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbwm_pkg::*;
  localparam int W = 18;
  logic         i_sys_clk;
  logic         i_resetn;
  logic         i_ce;
  sbwm_clks_t   clks;
  sbwm_pins_t   pins;
  logic         o_wr_ready;
  logic         o_rd_oe;
  logic         o_single_clk;
  logic [W-1:0] o_rd_data;
  logic [W-1:0] mm [16];
  int           fail_count = 0;
  int           num_checks = 0;

  sbwm_core #(.W(W)) DUT (
    .i_sys_clk   (i_sys_clk),
    .i_resetn    (i_resetn),
    .i_ce        (i_ce),
    .i_clks      (clks),
    .i_pins      (pins),
    .o_wr_ready  (o_wr_ready),
    .o_rd_data   (o_rd_data),
    .o_rd_oe     (o_rd_oe),
    .o_single_clk(o_single_clk)
  );
  sbwm_ctl_model ctl (
    .i_sys_clk(i_sys_clk),
    .o_clks   (clks),
    .o_pins   (pins)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  task automatic test_done();
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk_word(input string n, input logic [W-1:0] e, input logic [W-1:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask : chk_word

  task automatic chk_flag(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", n, e, g);
    end
  endtask : chk_flag

  function automatic logic [35:0] rnd();
    return 36'({$urandom(), $urandom()});
  endfunction : rnd

  function automatic logic [W-1:0] merge(input logic [W-1:0] o, input logic [35:0] n, input logic [3:0] s);
    for (int l = 0; l < 2; l++) begin
      if (!s[l]) begin
        o[l*9 +: 9] = n[l*9 +: 9];
      end
    end
    return o;
  endfunction : merge

  task automatic write(input logic [3:0] a, input logic [3:0] m0, input logic [3:0] m1);
    logic [35:0] w0;
    logic [35:0] w1;
    w0 = rnd();
    w1 = rnd();
    ctl.wr(a, w0, m0, w1, m1);
    mm[a] = merge(mm[a], w0, m0);
    mm[a + 4'h1] = merge(mm[a + 4'h1], w1, m1);
    chk_flag("wr_ready", 1'b1, o_wr_ready);
  endtask : write

  // sgl picks the input pair as output clocks
  task automatic read(input logic [3:0] a, input bit sgl);
    ctl.rd_start(a);
    chk_flag("rd_oe", 1'b0, o_rd_oe);
    ctl.pulse(sgl ? ctl.KN : ctl.CN);
    chk_flag("rd_oe", 1'b1, o_rd_oe);
    chk_word("rd_data", mm[a], o_rd_data);
    ctl.pulse(sgl ? ctl.K : ctl.C);
    chk_word("rd_data", mm[a + 4'h1], o_rd_data);
    ctl.pulse(sgl ? ctl.KN : ctl.CN);
    chk_flag("rd_oe", 1'b0, o_rd_oe);
  endtask : read

  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  initial begin
    void'($urandom(32'hde16));
    i_resetn = 1'b0;
    i_ce     = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_flag("rd_oe", 1'b0, o_rd_oe);
    chk_word("rd_data", '0, o_rd_data);
    chk_flag("wr_ready", 1'b1, o_wr_ready);
    i_resetn = 1'b1;
    ctl.cyc(6);
    chk_flag("single_clk", 1'b0, o_single_clk);
    for (int a = 0; a < 16; a++) begin
      write(4'(a), 4'h0, 4'h0);
    end
    // every first-portion select code, second portion set to that code shifted right by two
    for (int i = 0; i < 16; i++) begin
      write(4'($urandom()), 4'(i), 4'(i >> 2));
    end
    for (int i = 0; i < 12; i++) begin
      write(4'($urandom()), 4'($urandom()), 4'($urandom()));
    end
    // a frozen core must miss a whole burst, so the array keeps its words
    i_ce = 1'b0;
    ctl.wr(4'h3, rnd(), 4'h0, rnd(), 4'h0);
    i_ce = 1'b1;
    ctl.cyc(2);
    read(4'h3, 1'b0);
    read(4'hf, 1'b0);
    for (int i = 0; i < 6; i++) begin
      read(4'($urandom()), 1'b0);
    end
    ctl.stop();
    i_resetn = 1'b0;
    ctl.cyc(2);
    chk_flag("single_clk", 1'b0, o_single_clk);
    chk_flag("rd_oe", 1'b0, o_rd_oe);
    i_resetn = 1'b1;
    ctl.cyc(6);
    chk_flag("single_clk", 1'b1, o_single_clk);
    for (int i = 0; i < 6; i++) begin
      write(4'($urandom()), 4'($urandom()), 4'($urandom()));
      read(4'($urandom()), 1'b1);
    end
    test_done();
  end
endmodule : testbench
`default_nettype wire
